/* design/vrc_pkg.sv */
/*
 Constants of the voltage reference control block: register offsets,
 field positions, reset values and the settling count.
 Assumes a byte-wide peripheral bus with a one-bit address inside the block.
*/
package vrc_pkg;
    // Register offsets
    localparam logic [0:0] TRIM_OFFSET = 1'h0;
    localparam logic [0:0] SC_OFFSET = 1'h1;
    // Status and control fields
    localparam int ENABLE_BIT = 7;
    localparam int STABLE_BIT = 2;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;
    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [7:0] SC_WRITE_MASK = 8'h83;
    // Mode encodings
    typedef enum logic [1:0] {
        VRC_MODE_BANDGAP = 2'b00,
        VRC_MODE_LOW_POWER = 2'b01,
        VRC_MODE_TIGHT = 2'b10,
        VRC_MODE_RESERVED = 2'b11
    } vrc_mode_e;
    // Trim code landmarks, offset binary
    localparam logic [7:0] TRIM_CODE_MAX = 8'h80;
    localparam logic [7:0] TRIM_CODE_MID = 8'hff;
    localparam logic [7:0] TRIM_CODE_MIN = 8'h7f;
    localparam int TRIM_STEP_UV = 500;
    // Bandgap settling time in ns, and cycles at 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETTLE_TIME_NS = 10000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 12;
endpackage

/* design/vrc_voltage_reference_control.sv */
/*
 Voltage reference control: trim register, status and control register,
 settling timer, analog control outputs and instance decode.
 Assumes a byte-wide synchronous bus on sys_clk_i, single-cycle strobes,
 and a factory trim value and package strap that are stable at reset.
*/
// Contract
// [RULE1] Every reset loads the trim register with the factory value; one code step is 0.5 mV.
// [RULE2] The trim code is offset binary: 0x80 max, 0xff mid, 0x00 one step below mid, 0x7f min.
// [RULE3] Bit 7 enables the reference; when clear the bandgap and buffers are off.
// [RULE4] Bit 2 is a read-only stable flag, one only after startup completes.
// [RULE5] Bits 1:0 select bandgap only, low-power buffer, tight buffer, or reserved.
// [RULE6] Software uses low-power buffer mode only for internal loads, not the output pin.
// [RULE7] Reset sets the clock gate bit; clearing it stops the module's bus clock.
// [RULE8] After reset only the instance chosen by package is enabled.
// [RULE9] A disabled instance does not decode its registers.
// [RULE10] Operation is unchanged in run, wait and low-power modes, optionally in partial stop.
// [RULE11] Trim sits at offset 0 and status and control at offset 1, one byte each.
// [RULE12] Changing mode while enabled and stable keeps the stable flag set.
// [RULE13] Software polls the stable flag after enabling before using the reference.
// [RULE14] Bits 6 to 3 of status and control read zero and ignore writes.
`timescale 1ns/10ps
module vrc_voltage_reference_control (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Chip-level configuration
    input wire logic [7:0] factory_trim_i,
    input wire logic large_package_i,
    input wire logic instance_is_second_i,
    input wire logic peripheral_clock_gate_reg_i,
    input wire logic partial_stop_mode_i,
    input wire logic stop_keep_enable_i,
    // Register bus
    input wire logic bus_sel_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [0:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    output logic [7:0] bus_rdata_o,
    output logic bus_hit_o,
    // Analog control
    output logic [7:0] trim_code_o,
    output logic bandgap_on_o,
    output logic low_power_buffer_on_o,
    output logic tight_buffer_on_o,
    output logic instance_enabled_o
);
    logic [7:0] trim;
    logic [7:0] next_trim;
    logic enable;
    logic next_enable;
    logic [1:0] mode;
    logic [1:0] next_mode;
    logic stable;
    logic next_stable;
    logic [vrc_pkg::SETTLE_W-1:0] settle_cnt;
    logic [vrc_pkg::SETTLE_W-1:0] next_settle_cnt;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic inst_en;
    logic next_inst_en;
    logic first_cycle;
    logic clk_active;
    logic access;
    logic running;

    localparam logic [vrc_pkg::SETTLE_W-1:0] SETTLE_LAST =
        vrc_pkg::SETTLE_W'(vrc_pkg::SETTLE_CYCLES - 1);

    // Register view of status and control
    function automatic logic [7:0] sc_view(input logic en, input logic st, input logic [1:0] md);
        logic [7:0] v;
        v = 8'h00;
        v[vrc_pkg::ENABLE_BIT] = en;
        v[vrc_pkg::STABLE_BIT] = st;
        v[vrc_pkg::MODE_MSB:vrc_pkg::MODE_LSB] = md;
        return v; // [RULE14]
    endfunction

    // Gate bit off freezes the block as a gated clock would
    assign clk_active = peripheral_clock_gate_reg_i; // [RULE7]
    assign access = bus_sel_i & inst_en & clk_active; // [RULE9]
    assign running = enable & ~(partial_stop_mode_i & ~stop_keep_enable_i); // [RULE10]

    // Package strap caught in the first clocked cycle after reset
    always_comb begin
        next_inst_en = inst_en;
        if (first_cycle) begin
            next_inst_en = large_package_i ? ~instance_is_second_i : instance_is_second_i; // [RULE8]
        end
    end

    always_comb begin
        next_trim = trim;
        next_enable = enable;
        next_mode = mode;
        next_rdata = rdata;
        if (first_cycle) begin
            next_trim = factory_trim_i; // [RULE1]
        end else if (access && bus_wr_i) begin
            if (bus_addr_i == vrc_pkg::TRIM_OFFSET) begin // [RULE11]
                next_trim = bus_wdata_i;
            end else if (bus_addr_i == vrc_pkg::SC_OFFSET) begin
                next_enable = bus_wdata_i[vrc_pkg::ENABLE_BIT]; // [RULE3]
                next_mode = bus_wdata_i[vrc_pkg::MODE_MSB:vrc_pkg::MODE_LSB]; // [RULE5]
            end
        end
        if (access && bus_rd_i) begin
            if (bus_addr_i == vrc_pkg::TRIM_OFFSET) begin
                next_rdata = trim;
            end else begin
                next_rdata = sc_view(enable, stable, mode); // [RULE4]
            end
        end else if (!access) begin
            next_rdata = 8'h00;
        end
    end

    // Settling timer restarts whenever running rises (enable, or leaving partial stop), not on mode change
    always_comb begin
        next_settle_cnt = settle_cnt;
        next_stable = stable;
        if (!running) begin
            next_settle_cnt = '0;
            next_stable = 1'b0; // [RULE4]
        end else if (!stable) begin
            if (settle_cnt == SETTLE_LAST) begin
                next_stable = 1'b1;
            end else begin
                next_settle_cnt = settle_cnt + 1'b1;
            end
        end // [RULE12]
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            trim <= vrc_pkg::TRIM_CODE_MID;
            enable <= vrc_pkg::SC_RESET[vrc_pkg::ENABLE_BIT];
            mode <= vrc_pkg::SC_RESET[vrc_pkg::MODE_MSB:vrc_pkg::MODE_LSB];
            stable <= 1'b0;
            settle_cnt <= '0;
            rdata <= 8'h00;
            inst_en <= 1'b0;
            first_cycle <= 1'b1;
        end else if (clk_active || first_cycle) begin
            trim <= next_trim;
            enable <= next_enable;
            mode <= next_mode;
            stable <= next_stable;
            settle_cnt <= next_settle_cnt;
            rdata <= next_rdata;
            inst_en <= next_inst_en;
            first_cycle <= 1'b0;
        end
    end

    // Reserved mode acts as disabled
    always_comb begin
        bandgap_on_o = running && (mode != vrc_pkg::VRC_MODE_RESERVED); // [RULE3]
        low_power_buffer_on_o = bandgap_on_o && (mode == vrc_pkg::VRC_MODE_LOW_POWER); // [RULE5]
        tight_buffer_on_o = bandgap_on_o && (mode == vrc_pkg::VRC_MODE_TIGHT); // [RULE5]
    end

    assign trim_code_o = trim; // [RULE2]
    assign bus_rdata_o = rdata;
    assign bus_hit_o = access;
    assign instance_enabled_o = inst_en;
endmodule

/* verification/tb.sv */
/* Register-level bench of the reference control block.
 Assumes the analog model and checker are compiled alongside. */
`timescale 1ns/10ps
module tb;
    logic clk = 0, rst_n = 0, lg = 1, sec = 0, gate = 1, sel = 0, wr = 0, rd = 0, a = 0;
    logic stp = 0, keep = 0;
    logic [7:0] ft = 8'h5a, wd = 8'h00, rdata, trim, v;
    logic hit, bg, lp, tt, ien, pin;
    int drop, n_mismatch = 0, comparisons = 0;
    int rank[4] = '{0, 127, 128, 255};
    logic [7:0] code[4] = '{8'h80, 8'hff, 8'h00, 8'h7f};
    always #2.5 clk = ~clk;
    vrc_voltage_reference_control u_vrc_voltage_reference_control (.sys_clk_i(clk),
        .rst_n_i(rst_n), .factory_trim_i(ft), .large_package_i(lg), .instance_is_second_i(sec),
        .peripheral_clock_gate_reg_i(gate), .partial_stop_mode_i(stp), .stop_keep_enable_i(keep),
        .bus_sel_i(sel), .bus_wr_i(wr), .bus_rd_i(rd), .bus_addr_i(a), .bus_wdata_i(wd),
        .bus_rdata_o(rdata), .bus_hit_o(hit), .trim_code_o(trim), .bandgap_on_o(bg),
        .low_power_buffer_on_o(lp), .tight_buffer_on_o(tt), .instance_enabled_o(ien));
    vrc_analog_model u_vrc_analog_model (.trim_i(trim), .on_i(bg), .tight_i(tt),
        .drop_uv_o(drop), .pin_loaded_o(pin));
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task test_done;
        $display("%0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wb(input logic ad, input logic [7:0] d);
        @(posedge clk); sel <= 1; wr <= 1; a <= ad; wd <= d;
        @(posedge clk); sel <= 0; wr <= 0;
        #1;
    endtask
    task rb(input logic ad);
        @(posedge clk); sel <= 1; rd <= 1; a <= ad;
        @(posedge clk); sel <= 0; rd <= 0;
        #1 v = rdata;
    endtask
    task reset;
        @(posedge clk) rst_n <= 0;
        repeat (16) @(posedge clk);
        rst_n <= 1;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        reset;
        rb(0); chk(v, 8'h5a);
        rb(1); chk(v, 8'h00);
        wb(1, 8'h81); chk({bg, lp, tt}, 3'b110);
        rb(1); chk(v, 8'h81);
        // Settling is long; bounded poll
        for (int i = 0; i < 3000 && v[2] !== 1'b1; i++) rb(1);
        chk(v, 8'h85);
        $display("end of test 1");
        for (int m = 0; m < 4; m++) begin
            wb(1, {6'h3f, m[1:0]}); chk({bg, lp, tt}, {m != 3, m == 1, m == 2});
            if (m < 3) begin
                rb(1); chk(v, {6'h21, m[1:0]});
            end
        end
        wb(1, 8'h80);
        // Partial stop keeps the bandgap only when asked to
        @(posedge clk) {stp, keep} <= 2'b11;
        @(posedge clk) #1 chk(bg, 1'b1);
        @(posedge clk) keep <= 1'b0;
        @(posedge clk) #1 chk(bg, 1'b0);
        @(posedge clk) stp <= 1'b0;
        @(posedge clk) #1 chk(bg, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wb(0, code[i]); chk(drop, 500 * rank[i]);
            rb(0); chk(v, code[i]);
        end
        wb(1, 8'h00); chk({bg, pin}, 2'b00);
        rb(1); chk(v, 8'h00);
        $display("end of test 2");
        @(posedge clk) gate <= 0;
        wb(0, 8'h11);
        rb(0); chk(v, 8'h00);
        @(posedge clk) gate <= 1;
        rb(0); chk(v, 8'h7f);
        $display("end of test 3");
        for (int p = 0; p < 4; p++) begin
            @(posedge clk) {lg, sec} <= p[1:0];
            reset;
            chk(ien, p[1] ^ p[0]);
            rb(0); chk(v, (p[1] ^ p[0]) ? ft : 8'h00);
        end
        $display("end of test 4");
        test_done;
    end
endmodule

/* verification/vrc_analog_model.sv */
/* Analog far side: bandgap level and pin load.
 Assumes trim and enables come straight from the block. */
`timescale 1ns/10ps
module vrc_analog_model (
    // From the block
    input logic [7:0] trim_i,
    input logic on_i,
    input logic tight_i,
    // Observed level
    output int drop_uv_o,
    output logic pin_loaded_o
);
    // Offset binary: drop below max, -1 when off
    assign drop_uv_o = on_i ? 500 * int'(trim_i ^ 8'h80) : -1;
    // Pin load only with tight buffer on
    assign pin_loaded_o = tight_i;
endmodule

/* verification/vrc_chk.sv */
/* Bus and control checks on the block's ports.
 Assumes binding to the block top. */
`timescale 1ns/10ps
module vrc_chk (
    // Watched ports
    input logic sys_clk_i,
    input logic rst_n_i,
    input logic [7:0] factory_trim_i,
    input logic peripheral_clock_gate_reg_i,
    input logic bus_sel_i,
    input logic bus_wr_i,
    input logic bus_rd_i,
    input logic [0:0] bus_addr_i,
    input logic [7:0] bus_wdata_i,
    input logic [7:0] bus_rdata_o,
    input logic bus_hit_o,
    input logic [7:0] trim_code_o,
    input logic bandgap_on_o,
    input logic instance_enabled_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_trim_load: assert property (disable iff (1'b0) !rst_n_i ##1 rst_n_i
        |=> trim_code_o == $past(factory_trim_i)) else $error("factory trim not loaded");
    a_trim_write: assert property (bus_hit_o && bus_wr_i && !bus_addr_i
        |=> trim_code_o == $past(bus_wdata_i)) else $error("trim write lost");
    a_unused_zero: assert property (bus_hit_o && bus_rd_i && bus_addr_i
        |=> bus_rdata_o[6:3] == 4'h0) else $error("unused bits set");
    a_enable_off: assert property (bus_hit_o && bus_wr_i && bus_addr_i
        && !bus_wdata_i[7] |=> !bandgap_on_o) else $error("bandgap on while disabled");
    a_stable_low: assert property (bus_hit_o && bus_rd_i && bus_addr_i
        ##1 !bus_rdata_o[7] |-> !bus_rdata_o[2]) else $error("stable while disabled");
    a_hit_gated: assert property (bus_hit_o |-> bus_sel_i && instance_enabled_o
        && peripheral_clock_gate_reg_i) else $error("decode without enabled instance");
    a_miss_zero: assert property (bus_sel_i && !bus_hit_o
        |=> bus_rdata_o == 8'h00) else $error("data on refused access");
    a_gate_hold: assert property ($past(rst_n_i) && !peripheral_clock_gate_reg_i
        |=> $stable(trim_code_o)) else $error("trim moved with clock gated");
endmodule
bind vrc_voltage_reference_control vrc_chk u_vrc_chk (.*);
